// *** src/cocr_pkg.sv ***
// constants, types and helpers shared by the card operating-conditions register bank
// assumes a 200 MHz system clock and a host-driven card bus clock
package cocr_pkg;

	// system clock rate and power-up routine length
	localparam int CLK_MHZ            = 200;
	localparam int POWERUP_TIME_US    = 1000;
	localparam int POWERUP_CYCLES_DEF = POWERUP_TIME_US * CLK_MHZ;

	// command line framing
	localparam int FRAME_BITS  = 48;
	localparam int TURN_CYCLES = 2;

	// operating-conditions word layout
	localparam int OCR_DUAL_BIT = 7;
	localparam int OCR_VOLT_LSB = 15;
	localparam int OCR_VOLT_W   = 9;
	localparam int OCR_S18_BIT  = 24;
	localparam int OCR_CAP_BIT  = 30;
	localparam int OCR_DONE_BIT = 31;
	localparam logic [31:0] OCR_USED_MASK   = 32'hc1ff8080;
	localparam logic [8:0]  VOLT_WINDOW_DEF = 9'h1ff;
	localparam logic        S18_SUPPORT_DEF = 1'h1;
	localparam logic [15:0] CARD_RCA_DEF    = 16'h0001;

	// command indices
	localparam logic [5:0] CMD_GO_IDLE    = 6'h00;
	localparam logic [5:0] CMD_SEND_ID    = 6'h02;
	localparam logic [5:0] CMD_REL_ADDR   = 6'h03;
	localparam logic [5:0] CMD_SET_DRIVER = 6'h04;
	localparam logic [5:0] CMD_IF_COND    = 6'h08;
	localparam logic [5:0] CMD_STATUS     = 6'h0d;
	localparam logic [5:0] CMD_APP        = 6'h37;
	localparam logic [5:0] ACMD_OP_COND   = 6'h29;
	localparam logic [5:0] ACMD_STATUS    = 6'h0d;

	// long response to the operating-conditions query
	localparam logic [5:0] R3_INDEX = 6'h3f;
	localparam logic [6:0] R3_CRC   = 7'h7f;
	localparam logic [6:0] CRC_POLY = 7'h09;

	// status word layouts
	localparam int STA_STATE_LSB   = 9;
	localparam int STA_APP_BIT     = 5;
	localparam int STB_ILLEGAL_BIT = 0;
	localparam int STB_CRC_BIT     = 1;
	localparam int STB_INDEX_LSB   = 2;

	typedef enum logic [3:0] {
		CS_IDLE  = 4'h0,
		CS_READY = 4'h1,
		CS_IDENT = 4'h2,
		CS_STBY  = 4'h3
	} cocr_card_state_t;

	typedef enum logic [2:0] {
		LK_IDLE   = 3'h0,
		LK_RECV   = 3'h1,
		LK_DECODE = 3'h2,
		LK_WAIT   = 3'h3,
		LK_SEND   = 3'h4
	} cocr_link_state_t;

	// one command or response frame as it travels on the line, msb first
	typedef struct packed {
		logic       start;
		logic       dir;
		logic [5:0] index;
		logic [31:0] arg;
		logic [6:0] crc;
		logic       stop;
	} cocr_frame_t;

	// seven-bit checksum over the first forty bits of a frame
	function automatic logic [6:0] cocr_crc7(input logic [39:0] bits);
		logic [6:0] c;
		logic       fb;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			fb = bits[i] ^ c[6];
			c  = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
		end
		return c;
	endfunction

endpackage

// *** src/cocr_regs.sv ***
// card register bank: operating-conditions word, address and status registers
// assumes the host clocks the command line on sdClk and drives it only outside card responses
// Operation
// R1 - registers are reached only through their bus commands, with no other path; the code also copies the dual flag out on dualVoltageSeen.
// R2 - a 32-bit operating-conditions word carries voltage profile and status flags.
// R3 - the dual-voltage flag in bit 7 resets to zero and reads zero until CMD8 arrives.
// R4 - after CMD8 the dual-voltage flag reads one in every later response; the code clears it again on CMD0.
// R5 - bit 31 is set only once the power-up routine has finished and is low while busy.
// R6 - bit 30 gives capacity class, zero standard and one high or extended.
// R7 - the capacity bit is valid only once the power-up bit reads one.
// R8 - the host reads the capacity bit to tell the card classes apart.
// R9 - no driver-stage register exists, so its command is not served.
// R10 - a relative address register holds the setting, beside two separate status registers.
// R11 - the command line is sampled and driven on rising clock edges only.
// R12 - bits 15 to 23 flag each 100 mV supply range from 2.7 to 3.6 V.
// R13 - bit 24 reports whether a switch to 1.8 V signalling is accepted.
// R14 - every unassigned bit of the word reads zero.
module cocr_regs
	import cocr_pkg::*;
#(
	parameter int          POWERUP_CYCLES = POWERUP_CYCLES_DEF,
	parameter logic [8:0]  VOLT_WINDOW    = VOLT_WINDOW_DEF,
	parameter logic        S18_SUPPORT    = S18_SUPPORT_DEF,
	parameter logic [15:0] CARD_RCA       = CARD_RCA_DEF
) (
	// system side
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic highCapacityStrap,
	output logic      powerUpDone,
	output logic      dualVoltageSeen,
	// card bus, host-clocked
	input  wire logic sdClk,
	input  wire logic cmdIn,
	output logic      cmdOut,
	output logic      cmdOe
);
	localparam int PU_W = $clog2(POWERUP_CYCLES + 1);
	logic [PU_W-1:0]  puCount;
	logic [1:0]       strapSync;
	logic             strapTaken;
	logic             highCapacity;
	logic             linkReset_n;
	logic             upDoneLink;
	logic             capLink;
	cocr_link_state_t state;
	logic [5:0]       bitCount;
	logic [47:0]      rxShift;
	logic [47:0]      txShift;
	cocr_frame_t      rxFrame;
	logic             frameOk;
	logic             dualFlag;
	logic             appCmd;
	logic             illegalCmd;
	logic             crcErr;
	logic [5:0]       lastIndex;
	logic [15:0]      relativeAddress;
	cocr_card_state_t cardState;
	logic [31:0]      ocrWord;
	logic [31:0]      statusA;
	logic [31:0]      statusB;
	logic             respHas;
	logic             respLong;
	logic [31:0]      respArg;
	logic [39:0]      respHead;
	// power-up routine timer; done flag rises once and stays
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			puCount     <= '0;
			powerUpDone <= 1'b0;
		end else if (!powerUpDone) begin
			if (puCount == PU_W'(POWERUP_CYCLES - 1)) begin
				powerUpDone <= 1'b1; // R5
			end
			puCount <= puCount + PU_W'(1);
		end
	end
	// capacity strap and dual flag brought into the system domain
	cocr_sync2 #(.WIDTH(2)) u_sysSync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       ({highCapacityStrap, dualFlag}),
		.q       (strapSync)
	);
	assign dualVoltageSeen = strapSync[0];
	// strap followed while the routine runs, frozen just before the done bit is reported
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strapTaken   <= 1'b0;
			highCapacity <= 1'b0;
		end else if (!strapTaken) begin
			strapTaken   <= powerUpDone;
			highCapacity <= strapSync[1];
		end
	end
	// reset release and power-up status in the link domain
	cocr_sync2 #(.WIDTH(1)) u_linkRst (
		.clk     (sdClk),
		.reset_n (reset_n),
		.d       (1'b1),
		.q       (linkReset_n)
	);
	cocr_sync2 #(.WIDTH(2)) u_linkSync (
		.clk     (sdClk),
		.reset_n (reset_n),
		.d       ({highCapacity, powerUpDone & strapTaken}),
		.q       ({capLink, upDoneLink})
	);
	// operating-conditions word; unassigned bits stay zero
	always_comb begin
		ocrWord = 32'h00000000; // R14
		ocrWord[OCR_DONE_BIT] = upDoneLink; // R5
		ocrWord[OCR_CAP_BIT] = upDoneLink & capLink; // R6 R7
		ocrWord[OCR_S18_BIT] = S18_SUPPORT; // R13
		ocrWord[OCR_VOLT_LSB +: OCR_VOLT_W] = VOLT_WINDOW; // R12
		ocrWord[OCR_DUAL_BIT] = dualFlag; // R3 R4
	end
	// two separate status registers
	always_comb begin
		statusA = 32'h00000000;
		statusA[STA_STATE_LSB +: 4] = cardState; // R10
		statusA[STA_APP_BIT] = appCmd;
		statusB = 32'h00000000;
		statusB[STB_ILLEGAL_BIT] = illegalCmd; // R10
		statusB[STB_CRC_BIT] = crcErr;
		statusB[STB_INDEX_LSB +: 6] = lastIndex;
	end
	// received frame check
	assign rxFrame = cocr_frame_t'(rxShift);
	assign frameOk = !rxFrame.start && rxFrame.dir && rxFrame.stop
		&& (rxFrame.crc == cocr_crc7(rxShift[47:8]));
	// response selection; commands are the only way in or out on the card bus
	always_comb begin
		respHas   = 1'b0;
		respLong  = 1'b0;
		respArg   = statusA;
		if (appCmd && rxFrame.index == ACMD_OP_COND) begin
			respHas  = 1'b1; // R1 R2
			respLong = 1'b1;
			respArg  = ocrWord;
		end else if (appCmd && rxFrame.index == ACMD_STATUS) begin
			respHas = 1'b1;
			respArg = statusB;
		end else begin
			case (rxFrame.index)
				CMD_IF_COND: begin
					respHas = 1'b1;
					respArg = rxFrame.arg;
				end
				CMD_APP: respHas = 1'b1;
				CMD_STATUS: respHas = 1'b1;
				CMD_REL_ADDR: begin
					respHas = 1'b1;
					respArg = {CARD_RCA, 16'h0000};
				end
				CMD_SET_DRIVER: respHas = 1'b0; // R9
				default: respHas = 1'b0;
			endcase
		end
		respHead = {1'b0, 1'b0, respLong ? R3_INDEX : rxFrame.index, respArg};
	end
	// link sequencer: receive, decode, turnaround, send, all on rising edges
	always_ff @(posedge sdClk or negedge linkReset_n) begin
		if (!linkReset_n) begin
			state    <= LK_IDLE;
			bitCount <= 6'h00;
		end else begin
			case (state)
				LK_IDLE: begin
					if (!cmdIn) begin
						state    <= LK_RECV; // R11
						bitCount <= 6'h01;
					end
				end
				LK_RECV: begin
					bitCount <= bitCount + 6'h01;
					if (bitCount == 6'(FRAME_BITS - 1)) begin
						state <= LK_DECODE;
					end
				end
				LK_DECODE: begin
					bitCount <= 6'h00;
					state    <= (frameOk && respHas) ? LK_WAIT : LK_IDLE;
				end
				LK_WAIT: begin
					bitCount <= bitCount + 6'h01;
					if (bitCount == 6'(TURN_CYCLES - 1)) begin
						state    <= LK_SEND;
						bitCount <= 6'h00;
					end
				end
				LK_SEND: begin
					bitCount <= bitCount + 6'h01;
					if (bitCount == 6'(FRAME_BITS - 1)) begin
						state <= LK_IDLE;
					end
				end
				default: state <= LK_IDLE;
			endcase
		end
	end
	// command shift-in, sampled on the rising edge
	always_ff @(posedge sdClk or negedge linkReset_n) begin
		if (!linkReset_n) begin
			rxShift <= 48'h000000000000;
		end else if (state == LK_IDLE || state == LK_RECV) begin
			rxShift <= {rxShift[46:0], cmdIn}; // R11
		end
	end
	// response shift-out, driven from the rising edge
	always_ff @(posedge sdClk or negedge linkReset_n) begin
		if (!linkReset_n) begin
			txShift <= 48'h000000000000;
			cmdOut  <= 1'b1;
			cmdOe   <= 1'b0;
		end else if (state == LK_DECODE) begin
			txShift <= {respHead, respLong ? R3_CRC : cocr_crc7(respHead), 1'b1};
		end else if (state == LK_SEND
			|| (state == LK_WAIT && bitCount == 6'(TURN_CYCLES - 1))) begin
			cmdOe   <= state == LK_WAIT || bitCount != 6'(FRAME_BITS - 1); // R11
			cmdOut  <= txShift[47];
			txShift <= {txShift[46:0], 1'b1};
		end
	end
	// card registers written only by decoded commands
	always_ff @(posedge sdClk or negedge linkReset_n) begin
		if (!linkReset_n) begin
			dualFlag        <= 1'b0; // R3
			appCmd          <= 1'b0;
			illegalCmd      <= 1'b0;
			crcErr          <= 1'b0;
			lastIndex       <= 6'h00;
			relativeAddress <= 16'h0000;
			cardState       <= CS_IDLE;
		end else if (state == LK_DECODE && !frameOk) begin
			crcErr <= 1'b1;
		end else if (state == LK_DECODE) begin
			lastIndex  <= rxFrame.index;
			crcErr     <= crcErr && !(appCmd && rxFrame.index == ACMD_STATUS); // held until read
			appCmd     <= rxFrame.index == CMD_APP;
			illegalCmd <= (illegalCmd && !(appCmd && rxFrame.index == ACMD_STATUS))
				|| (!respHas && rxFrame.index != CMD_GO_IDLE
				&& rxFrame.index != CMD_SEND_ID); // R9
			if (rxFrame.index == CMD_GO_IDLE) begin
				dualFlag  <= 1'b0;
				cardState <= CS_IDLE;
			end else if (rxFrame.index == CMD_IF_COND && !appCmd) begin
				dualFlag <= 1'b1; // R4
			end else if (appCmd && rxFrame.index == ACMD_OP_COND && upDoneLink) begin
				cardState <= CS_READY;
			end else if (rxFrame.index == CMD_SEND_ID && cardState == CS_READY) begin
				cardState <= CS_IDENT;
			end else if (rxFrame.index == CMD_REL_ADDR) begin
				relativeAddress <= CARD_RCA; // R10
				cardState       <= CS_STBY;
			end
		end
	end
	// checks in the link domain, and the power-up timing check on clk
	AST_DONE_TRACKS: assert property (@(posedge sdClk) disable iff (!linkReset_n) // R5
		ocrWord[OCR_DONE_BIT] == upDoneLink && (powerUpDone || !ocrWord[OCR_DONE_BIT]))
		else $error("power-up bit does not follow the routine");
	AST_CAP_GATED: assert property (@(posedge sdClk) disable iff (!linkReset_n) // R7
		!ocrWord[OCR_DONE_BIT] |-> !ocrWord[OCR_CAP_BIT]) else $error("capacity bit shown while busy");
	AST_CAP_VALUE: assert property (@(posedge sdClk) disable iff (!linkReset_n) // R6
		ocrWord[OCR_DONE_BIT] |-> ocrWord[OCR_CAP_BIT] == capLink)
		else $error("capacity bit wrong after power-up");
	AST_DUAL_SET: assert property (@(posedge sdClk) disable iff (!linkReset_n) // R4
		state == LK_DECODE && frameOk && !appCmd && rxFrame.index == CMD_IF_COND
		|=> dualFlag && ocrWord[OCR_DUAL_BIT])
		else $error("dual-voltage flag not set after CMD8");
	AST_DUAL_CAUSE: assert property (@(posedge sdClk) disable iff (!linkReset_n) // R3
		$rose(dualFlag) |-> $past(state) == LK_DECODE && $past(rxFrame.index) == CMD_IF_COND)
		else $error("dual-voltage flag rose without CMD8");
	AST_RESERVED: assert property (@(posedge sdClk) disable iff (!linkReset_n) // R14
		(ocrWord & ~OCR_USED_MASK) == 32'h00000000)
		else $error("unassigned bit set in operating-conditions word");
	AST_VOLT_S18: assert property (@(posedge sdClk) disable iff (!linkReset_n) // R12
		ocrWord[OCR_VOLT_LSB +: OCR_VOLT_W] == VOLT_WINDOW && ocrWord[OCR_S18_BIT] == S18_SUPPORT)
		else $error("voltage window or 1.8 V bit wrong");
	AST_NO_DRIVER: assert property (@(posedge sdClk) disable iff (!linkReset_n) // R9
		state == LK_DECODE && !appCmd && rxFrame.index == CMD_SET_DRIVER
		|=> state == LK_IDLE ##1 !cmdOe [*2])
		else $error("driver-stage command answered");
	AST_RCA_LOAD: assert property (@(posedge sdClk) disable iff (!linkReset_n) // R10
		state == LK_DECODE && frameOk && rxFrame.index == CMD_REL_ADDR
		|=> relativeAddress == CARD_RCA && cardState == CS_STBY)
		else $error("relative address not stored");
	AST_SEND_LEN: assert property (@(posedge sdClk) disable iff (!linkReset_n) // R11
		$rose(cmdOe) |-> cmdOe [*8] ##40 cmdOe ##1 !cmdOe)
		else $error("response length wrong");
	AST_PU_TIME: assert property (@(posedge clk) disable iff (!reset_n) // R5
		$rose(powerUpDone) |-> $past(puCount) == PU_W'(POWERUP_CYCLES - 1))
		else $error("power-up finished at the wrong time");
	COV_OP_COND_READY: cover property (@(posedge sdClk) disable iff (!linkReset_n)
		state == LK_DECODE && appCmd && rxFrame.index == ACMD_OP_COND && upDoneLink);
	COV_DUAL: cover property (@(posedge sdClk) disable iff (!linkReset_n) $rose(dualFlag));
	COV_STBY: cover property (@(posedge sdClk) disable iff (!linkReset_n)
		$rose(cardState == CS_STBY));
endmodule // cocr_regs

// *** src/cocr_regs_tail.sv ***
// no logic of its own: the bank is cocr_regs with its synchroniser cocr_sync2
// assumes nothing of its surroundings

// *** src/cocr_sync2.sv ***
// two flip-flop synchroniser for levels entering a clock domain
// assumes each bit is a slow level, not a pulse
module cocr_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset of the receiving domain
	input  wire logic             clk,
	input  wire logic             reset_n,
	// level in and synchronised level out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;

	// first stage is read only by the second
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule // cocr_sync2

// *** test/cocr_host_model.sv ***
// host-side model of the card bus: makes the bus clock and sends command frames
// assumes the bench merges cmdOut and cmdOe with hostCmd into the card's cmdIn
module cocr_host_model (
	// card bus
	output logic      sdClk,
	output logic      hostCmd,
	input  wire logic cmdOut,
	input  wire logic cmdOe
);
	timeunit 1ns;
	timeprecision 100ps;

	logic lineOe;
	logic lineBit;

	// clock stands still and the line is released high between frames
	initial begin
		sdClk = 1'b0;
		hostCmd = 1'b1;
	end

	// checksum over the first forty bits of a frame
	function automatic logic [6:0] crc7(input logic [39:0] b);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			c = {c[5:0], 1'b0} ^ ((b[i] ^ c[6]) ? 7'h09 : 7'h00);
		end
		return c;
	endfunction

	// one bus clock; the line changes only while low, sampled at the rising edge
	task automatic tick();
		#16;
		lineOe = cmdOe;
		lineBit = cmdOut;
		sdClk = 1'b1;
		#16 sdClk = 1'b0;
	endtask

	// bus clocks with the line idle
	task automatic idle(input int n);
		repeat (n) tick();
	endtask

	// send one command, then collect a 48-bit response if one comes
	task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input logic bad,
		output logic [47:0] resp, output logic got);
		logic [47:0] f;
		int n;
		f = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {6'h00, bad}, 1'b1};
		for (int i = 47; i >= 0; i--) begin
			hostCmd = f[i];
			tick();
		end
		hostCmd = 1'b1; // pull-up holds the released line high
		resp = '0;
		n = 0;
		for (int k = 0; k < 60 && n < 48; k++) begin
			tick();
			if (lineOe === 1'b1) begin
				resp = {resp[46:0], lineBit};
				n++;
			end
		end
		got = (n == 48);
		idle(2);
	endtask
endmodule // cocr_host_model

// *** test/cocr_regs_tb.sv ***
// self-checking bench of the card register bank, driven through the command line
// assumes the host model on the far side and a shortened power-up count
module cocr_regs_tb
	import cocr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int          PUP = 4000;
	localparam logic [15:0] RELATIVE_ADDRESS_REG = 16'h5a3c;

	logic        clk;
	logic        reset_n;
	logic        highCapacityStrap;
	logic        powerUpDone;
	logic        dualVoltageSeen;
	logic        sdClk;
	logic        cmdOut;
	logic        cmdOe;
	logic        hostCmd;
	wire         cmdIn;
	int          failures;
	int          checked;
	logic [31:0] seed;
	logic [47:0] resp;
	logic        got;

	// shared command wire: card drives while enabled, host otherwise
	assign cmdIn = cmdOe ? cmdOut : hostCmd;

	cocr_regs #(.POWERUP_CYCLES(PUP), .CARD_RCA(RELATIVE_ADDRESS_REG)) cocr_regs_i (
		.clk               (clk),
		.reset_n           (reset_n),
		.highCapacityStrap (highCapacityStrap),
		.powerUpDone       (powerUpDone),
		.dualVoltageSeen   (dualVoltageSeen),
		.sdClk             (sdClk),
		.cmdIn             (cmdIn),
		.cmdOut            (cmdOut),
		.cmdOe             (cmdOe)
	);

	cocr_host_model cocr_host_model_i (
		.sdClk   (sdClk),
		.hostCmd (hostCmd),
		.cmdOut  (cmdOut),
		.cmdOe   (cmdOe)
	);

	// system clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// expected word; the capacity bit is only trusted once power-up is done
	function automatic logic [31:0] exp_ocr(input logic done, input logic cap, input logic dual);
		return {done, done & cap, 5'h00, S18_SUPPORT_DEF, VOLT_WINDOW_DEF, 7'h00, dual, 7'h00};
	endfunction

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic bad);
		cocr_host_model_i.xfer(idx, arg, bad, resp, got);
	endtask

	// query the word through the app prefix and compare the full response frame
	task automatic ocr_check(input logic done, input logic dual);
		cmd(CMD_APP, 32'h0, 1'b0);
		cmd(ACMD_OP_COND, 32'h40ff8000, 1'b0);
		check({47'h0, got}, 48'h1);
		check(resp, {2'b00, R3_INDEX, exp_ocr(done, highCapacityStrap, dual), R3_CRC, 1'b1});
	endtask

	task automatic do_reset(input logic strap);
		@(posedge clk);
		reset_n <= 1'b0;
		highCapacityStrap <= strap;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		cocr_host_model_i.idle(4);
	endtask

	// main sequence: two reset passes, one per capacity class
	initial begin
		reset_n = 1'b0;
		highCapacityStrap = 1'b0;
		failures = 0;
		checked = 0;
		seed = 32'h6781;
		for (int p = 0; p < 2; p++) begin
			do_reset(seed[0] ^ p[0]);
			check({47'h0, powerUpDone}, 48'h0);
			ocr_check(1'b0, 1'b0);
			repeat (3) begin
				seed = next_rand(seed);
				cmd(CMD_IF_COND, seed, 1'b0);
				check(resp, {2'b00, CMD_IF_COND, seed,
					cocr_host_model_i.crc7({2'b00, CMD_IF_COND, seed}), 1'b1});
			end
			check({47'h0, dualVoltageSeen}, 48'h1);
			for (int w = 0; w < 6000 && powerUpDone !== 1'b1; w++) begin
				@(posedge clk);
			end
			ocr_check(1'b1, 1'b1);
			cmd(CMD_SEND_ID, 32'h0, 1'b0);
			cmd(CMD_REL_ADDR, 32'h0, 1'b0);
			check(resp, {2'b00, CMD_REL_ADDR, RELATIVE_ADDRESS_REG, 16'h0000,
				cocr_host_model_i.crc7({2'b00, CMD_REL_ADDR, RELATIVE_ADDRESS_REG, 16'h0000}), 1'b1});
			cmd(CMD_STATUS, {RELATIVE_ADDRESS_REG, 16'h0000}, 1'b0);
			check({44'h0, resp[20:17]}, 48'h3);
			cmd(CMD_SET_DRIVER, 32'h0, 1'b0);
			check({47'h0, got}, 48'h0);
			cmd(CMD_STATUS, {RELATIVE_ADDRESS_REG, 16'h0000}, 1'b1);
			check({47'h0, got}, 48'h0);
			cmd(CMD_APP, {RELATIVE_ADDRESS_REG, 16'h0000}, 1'b0);
			cmd(ACMD_STATUS, 32'h0, 1'b0);
			check({46'h0, resp[9:8]}, 48'h3);
			check({42'h0, resp[15:10]}, {42'h0, CMD_APP});
			cmd(CMD_APP, 32'h0, 1'b0);
			cmd(ACMD_STATUS, 32'h0, 1'b0);
			check({46'h0, resp[9:8]}, 48'h0);
			cmd(CMD_GO_IDLE, 32'h0, 1'b0);
			check({47'h0, dualVoltageSeen}, 48'h0);
			ocr_check(1'b1, 1'b0);
		end
		complete_run();
	end

	// watchdog against a hung handshake
	initial begin
		#400us;
		failures++;
		complete_run();
	end
endmodule // cocr_regs_tb
